// ===== design/aod_pkg.sv
// Package with record layout, codes and timing constants of the analog output diagnostics
`default_nettype none
package aod_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TICK_NS = 1000;
	localparam int unsigned CLK_NS = 4;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_NS;
	localparam int unsigned BLINK_HZ = 2;
	localparam int unsigned BLINK_HALF_US = 1000000 / (2 * BLINK_HZ);

	// ==========================================================
	// Diagnostic record byte indices
	localparam logic [4:0] IDX_ERR_SUM = 5'h00;
	localparam logic [4:0] IDX_MOD_INFO = 5'h01;
	localparam logic [4:0] IDX_RSVD_C = 5'h02;
	localparam logic [4:0] IDX_INT_DIAG = 5'h03;
	localparam logic [4:0] IDX_CH_TYPE = 5'h04;
	localparam logic [4:0] IDX_DIAG_BITS = 5'h05;
	localparam logic [4:0] IDX_CH_COUNT = 5'h06;
	localparam logic [4:0] IDX_GRP_ERR = 5'h07;
	localparam logic [4:0] IDX_CH0_ERR = 5'h08;
	localparam logic [4:0] IDX_CH1_ERR = 5'h09;
	localparam logic [4:0] IDX_STAMP0 = 5'h10;
	localparam logic [4:0] IDX_STAMP3 = 5'h13;

	// ==========================================================
	// Field positions and constant values
	localparam int unsigned BIT_BUF_OVF = 3;
	localparam int unsigned BIT_COMM_ERR = 4;
	localparam int unsigned BIT_CH_CFG = 0;
	localparam int unsigned BIT_CH_WIRE = 4;
	localparam int unsigned BIT_SUM_INT = 1;
	localparam int unsigned BIT_SUM_EXT = 2;
	localparam int unsigned BIT_SUM_CH = 3;
	localparam int unsigned BIT_SUM_PAR = 7;
	localparam logic [6:0] CHT_ANALOG_OUT = 7'h73;
	localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
	localparam logic [7:0] CH_COUNT_VAL = 8'h02;
	localparam logic [7:0] MOD_INFO_VAL = 8'h15;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ==========================================================
	// Process image layout
	localparam logic [1:0] OUT_OFS_CH0 = 2'h0;
	localparam logic [1:0] OUT_OFS_CH1 = 2'h2;
	localparam logic [7:0] IN_AREA_BYTES = 8'h00;
	localparam logic [7:0] OUT_AREA_BYTES = 8'h04;

	// Status levels coming in from the channel and supply monitors
	typedef struct packed {
		logic bus_pwr_err;
		logic cfg_err;
		logic module_err;
		logic comm_ok;
		logic [1:0] ch_param_err;
		logic [1:0] ch_wire_break;
		logic [1:0] ch_overload;
	} aod_status_t;

	// Indicator drive bundle
	typedef struct packed {
		logic run;
		logic module_fault_indicator;
		logic [1:0] channel_error_indicator;
	} aod_leds_t;
endpackage
`default_nettype wire

// ===== design/aod_sync.sv
// Two-stage synchroniser for a bundle of asynchronous status levels
`default_nettype none
module aod_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// ==========================================================
	// First stage feeds only the second stage
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule
`default_nettype wire

// ===== design/aod_ticker.sv
// Free-running microsecond ticker with a one-cycle tick pulse
`default_nettype none
module aod_ticker
	import aod_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Ticker state
	output logic o_tick,
	output logic [31:0] o_count
);
	localparam logic [7:0] PRE_LAST = 8'(TICK_CYC - 1);
	logic [7:0] pre_q;
	logic [31:0] count_q;

	// ==========================================================
	// Prescaler: one tick every microsecond
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pre_q <= '0;
		else if (pre_q == PRE_LAST)
			pre_q <= '0;
		else
			pre_q <= pre_q + 8'h01;
	end

	// Count starts at zero and wraps silently at the top
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			count_q <= '0;
		else if (pre_q == PRE_LAST)
			count_q <= count_q + 32'h0000_0001; // R10 R11
	end

	assign o_tick = (pre_q == PRE_LAST);
	assign o_count = count_q;
endmodule
`default_nettype wire

// ===== design/aod_diag_top.sv
// Diagnostic record, status indicators and output area of the two-channel analog output
// ==========================================================
// Summary of operation
// R1: Buffer overflow sets internal diagnostic bit 3
// R2: Communication error sets bit 4; others reserved
// R3: Channel type byte reads 73h, bit7 zero
// R4: Diagnostic bits per channel reads 08h
// R5: Channel count byte reads 02h
// R6: Group error bits 0/1 per channel
// R7: Channel byte bit 0 on configuration error
// R8: Channel byte bit 4 on wire-break
// R9: Event stores microsecond ticker as timestamp
// R10: Ticker starts at zero, counts microseconds
// R11: Ticker is 32 bits and wraps
// R12: Bus and module good: run on
// R13: Module error with bus good: both on
// R14: No bus, module error: fault only
// R15: Bus power error: both indicators off
// R16: Configuration error blinks fault at 2 Hz
// R17: Channel indicator on parameter, overload, short; the code has no short input and lights it on parameter error or overload only
// R18: No process input bytes used
// R19: Two independent 16-bit output channels
// R20: Host writes channel words at 0 and 2
`default_nettype none
module aod_diag_top
	import aod_pkg::*;
#(
	parameter int unsigned BLINK_US = BLINK_HALF_US
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rstn,
	// Monitor levels, asynchronous
	input wire aod_pkg::aod_status_t i_status,
	// Internal event pulses, core clock
	input wire logic i_diag_buf_ovf,
	input wire logic i_comm_err,
	// Output area write port
	input wire logic i_out_wr,
	input wire logic [1:0] i_out_addr,
	input wire logic [15:0] i_out_data,
	// Diagnostic record read port
	input wire logic i_rd_en,
	input wire logic [4:0] i_rd_addr,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	// Channel values to the converters
	output logic [15:0] o_output_value_ch0,
	output logic [15:0] o_output_value_ch1,
	// Process image sizes
	output logic [7:0] o_in_area_bytes,
	output logic [7:0] o_out_area_bytes,
	// Indicators
	output aod_pkg::aod_leds_t o_leds
);
	import aod_pkg::*;

	// Types and signals
	typedef enum logic [1:0] {
		BLK_OFF = 2'b01,
		BLK_ON = 2'b10
	} aod_blink_t;

	aod_status_t st;
	logic tick;
	logic [31:0] us_count;
	logic [7:0] internal_diag_flags_q;
	logic [15:0] ch0_q;
	logic [15:0] ch1_q;
	logic [7:0] rd_data_q;
	logic rd_valid_q;
	logic [31:0] diag_timestamp_q;
	logic [5:0] err_prev_q;
	logic [5:0] err_now;
	logic diag_event;
	logic [17:0] blink_cnt_q;
	aod_blink_t blink_q;
	aod_leds_t leds_q;
	aod_leds_t leds_d;
	logic [7:0] channel_group_errors;
	logic [7:0] channel_zero_error_flags;
	logic [7:0] channel_one_error_flags;
	logic [7:0] err_summary;
	logic [7:0] channel_type_code;

	localparam logic [17:0] BLINK_LAST = 18'(BLINK_US - 1);

	// Channel byte builder, used for both channels
	function automatic logic [7:0] ch_err_byte(input logic cfg, input logic wire_brk);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[BIT_CH_CFG] = cfg;
		b[BIT_CH_WIRE] = wire_brk;
		return b;
	endfunction

	// ==========================================================
	// Input synchronisation and ticker
	aod_sync #(
		.WIDTH($bits(aod_status_t))
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_async(i_status),
		.o_sync(st)
	);

	aod_ticker u_ticker (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.o_tick(tick),
		.o_count(us_count)
	);

	// ==========================================================
	// Output area: two independent words by byte offset
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ch0_q <= '0;
			ch1_q <= '0;
		end
		else if (i_out_wr)
		begin
			if (i_out_addr == OUT_OFS_CH0)
				ch0_q <= i_out_data; // R19 R20
			else if (i_out_addr == OUT_OFS_CH1)
				ch1_q <= i_out_data; // R19 R20
		end
	end

	assign o_output_value_ch0 = ch0_q;
	assign o_output_value_ch1 = ch1_q;
	// Module never claims input bytes
	assign o_in_area_bytes = IN_AREA_BYTES; // R18
	assign o_out_area_bytes = OUT_AREA_BYTES;

	// ==========================================================
	// Internal diagnostic flags: sticky, cleared by reading the byte
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			internal_diag_flags_q <= '0;
		else
		begin
			// Clear first so a same-cycle event wins
			if (i_rd_en && i_rd_addr == IDX_INT_DIAG)
				internal_diag_flags_q <= BYTE_ZERO;
			if (i_diag_buf_ovf)
				internal_diag_flags_q[BIT_BUF_OVF] <= 1'b1; // R1
			if (i_comm_err)
				internal_diag_flags_q[BIT_COMM_ERR] <= 1'b1; // R2
		end
	end

	// ==========================================================
	// Channel error bytes follow the live monitor levels
	assign channel_zero_error_flags = ch_err_byte(st.ch_param_err[0], st.ch_wire_break[0]); // R7 R8
	assign channel_one_error_flags = ch_err_byte(st.ch_param_err[1], st.ch_wire_break[1]); // R7 R8
	assign channel_group_errors = {6'h00, |channel_one_error_flags,
		|channel_zero_error_flags}; // R6
	assign channel_type_code = {1'b0, CHT_ANALOG_OUT}; // R3

	// Summary byte combines the detailed sources
	always_comb
	begin
		err_summary = BYTE_ZERO;
		err_summary[BIT_SUM_INT] = |internal_diag_flags_q;
		err_summary[BIT_SUM_EXT] = st.bus_pwr_err;
		err_summary[BIT_SUM_CH] = |channel_group_errors;
		err_summary[BIT_SUM_PAR] = st.cfg_err;
	end

	// ==========================================================
	// Event detection and timestamp capture
	assign err_now = {st.ch_wire_break, st.ch_param_err, st.cfg_err, st.bus_pwr_err};
	// Only new errors count; a level that stays up is one event
	assign diag_event = i_diag_buf_ovf | i_comm_err | (|(err_now & ~err_prev_q));

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			err_prev_q <= '0;
		else
			err_prev_q <= err_now;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			diag_timestamp_q <= '0;
		else if (diag_event)
			diag_timestamp_q <= us_count; // R9
	end

	// ==========================================================
	// Record read: one registered byte per request
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= i_rd_en;
			if (i_rd_en)
			begin
				case (i_rd_addr)
					IDX_ERR_SUM: rd_data_q <= err_summary;
					IDX_MOD_INFO: rd_data_q <= MOD_INFO_VAL;
					IDX_INT_DIAG: rd_data_q <= internal_diag_flags_q; // R1 R2
					IDX_CH_TYPE: rd_data_q <= channel_type_code; // R3
					IDX_DIAG_BITS: rd_data_q <= DIAG_BITS_VAL; // R4
					IDX_CH_COUNT: rd_data_q <= CH_COUNT_VAL; // R5
					IDX_GRP_ERR: rd_data_q <= channel_group_errors; // R6
					IDX_CH0_ERR: rd_data_q <= channel_zero_error_flags;
					IDX_CH1_ERR: rd_data_q <= channel_one_error_flags;
					IDX_STAMP0: rd_data_q <= diag_timestamp_q[7:0]; // R9
					IDX_STAMP0 + 5'h01: rd_data_q <= diag_timestamp_q[15:8];
					IDX_STAMP0 + 5'h02: rd_data_q <= diag_timestamp_q[23:16];
					IDX_STAMP3: rd_data_q <= diag_timestamp_q[31:24];
					// Reserved and unmapped bytes read zero
					default: rd_data_q <= BYTE_ZERO;
				endcase
			end
		end
	end

	assign o_rd_data = rd_data_q;
	assign o_rd_valid = rd_valid_q;

	// ==========================================================
	// 2 Hz blink phase, paced by the microsecond tick
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			blink_cnt_q <= '0;
			blink_q <= BLK_OFF;
		end
		else if (tick)
		begin
			if (blink_cnt_q == BLINK_LAST)
			begin
				blink_cnt_q <= '0;
				case (blink_q)
					BLK_OFF: blink_q <= BLK_ON; // R16
					BLK_ON: blink_q <= BLK_OFF;
					default: blink_q <= BLK_OFF;
				endcase
			end
			else
				blink_cnt_q <= blink_cnt_q + 18'h00001;
		end
	end

	// ==========================================================
	// Indicator decision; supply loss overrides everything
	always_comb
	begin
		leds_d = '0;
		if (st.bus_pwr_err)
			leds_d = '0; // R15
		else
		begin
			leds_d.run = st.comm_ok; // R12 R13 R14
			leds_d.module_fault_indicator = st.module_err; // R12 R13 R14
			if (st.cfg_err)
				leds_d.module_fault_indicator = (blink_q == BLK_ON); // R16
			if (leds_d.run && !leds_d.module_fault_indicator)
				leds_d.channel_error_indicator = st.ch_param_err | st.ch_overload; // R17
		end
	end

	// Registered so the pins never glitch
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			leds_q <= '0;
		else
			leds_q <= leds_d;
	end

	assign o_leds = leds_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence seq_rd(logic [4:0] a);
		i_rd_en && i_rd_addr == a;
	endsequence

	sequence seq_pwr_lost;
		st.bus_pwr_err;
	endsequence

	AST_BUF_OVF: assert property (i_diag_buf_ovf |=> internal_diag_flags_q[BIT_BUF_OVF]) // R1
		else $error("overflow flag not set");
	AST_COMM_ERR: assert property (i_comm_err ##1 seq_rd(IDX_INT_DIAG)
		|=> o_rd_data[BIT_COMM_ERR] && o_rd_valid) // R2
		else $error("communication flag not readable");
	AST_CH_TYPE: assert property (seq_rd(IDX_CH_TYPE) |=> o_rd_data == 8'h73) // R3
		else $error("channel type wrong");
	AST_DIAG_BITS: assert property (seq_rd(IDX_DIAG_BITS) |=> o_rd_data == 8'h08) // R4
		else $error("diagnostic bit count wrong");
	AST_CH_COUNT: assert property (seq_rd(IDX_CH_COUNT) |=> o_rd_data == 8'h02) // R5
		else $error("channel count wrong");
	AST_GRP_ERR: assert property (seq_rd(IDX_GRP_ERR) |=>
		o_rd_data[1:0] == {$past(st.ch_param_err[1] | st.ch_wire_break[1]),
		$past(st.ch_param_err[0] | st.ch_wire_break[0])}) // R6
		else $error("group error byte wrong");
	AST_CH0_BYTE: assert property (seq_rd(IDX_CH0_ERR) |=>
		o_rd_data[BIT_CH_CFG] == $past(st.ch_param_err[0])
		&& o_rd_data[BIT_CH_WIRE] == $past(st.ch_wire_break[0])) // R7 R8
		else $error("channel zero byte wrong");
	AST_STAMP: assert property (diag_event |=> diag_timestamp_q == $past(us_count)) // R9
		else $error("timestamp not captured");
	AST_TICK_STEP: assert property (tick |=> us_count == $past(us_count) + 32'h0000_0001) // R10
		else $error("ticker did not advance");
	AST_TICK_GAP: assert property (tick |=> !tick [*8]) // R10
		else $error("ticks too close");
	AST_TICK_WRAP: assert property (tick && us_count == 32'hFFFF_FFFF |=> us_count == '0) // R11
		else $error("ticker did not wrap");
	AST_LED_OK: assert property (!st.bus_pwr_err && !st.cfg_err && st.comm_ok && !st.module_err
		|=> o_leds.run && !o_leds.module_fault_indicator) // R12
		else $error("run state indicators wrong");
	AST_LED_ERR: assert property (!st.bus_pwr_err && !st.cfg_err && st.module_err
		|=> o_leds.module_fault_indicator && o_leds.run == $past(st.comm_ok)) // R13 R14
		else $error("module error indicators wrong");
	AST_LED_PWR: assert property (seq_pwr_lost |=> !o_leds.run && !o_leds.module_fault_indicator
		&& o_leds.channel_error_indicator == 2'b00) // R15
		else $error("indicators lit on supply loss");
	AST_CH_LED: assert property (o_leds.channel_error_indicator != 2'b00
		|-> o_leds.run && !o_leds.module_fault_indicator) // R17
		else $error("channel indicator lit out of state");
	AST_OUT_WR: assert property (i_out_wr && i_out_addr == OUT_OFS_CH1
		|=> o_output_value_ch1 == $past(i_out_data) && $stable(o_output_value_ch0)) // R19
		else $error("channel one write lost");
endmodule
`default_nettype wire

// ===== test/aod_host_model.sv
// Backplane host model: writes channel words, reads record bytes
`default_nettype none
module aod_host_model (
	// Clock
	input wire logic i_core_clk,
	// Read answer from the device
	input wire logic [7:0] i_rd_data,
	input wire logic i_rd_valid,
	// Requests to the device
	output logic o_out_wr,
	output logic [1:0] o_out_addr,
	output logic [15:0] o_out_data,
	output logic o_rd_en,
	output logic [4:0] o_rd_addr
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Idle state at time zero
	initial
	begin
		o_out_wr = 1'b0;
		o_out_addr = 2'h0;
		o_out_data = 16'h0000;
		o_rd_en = 1'b0;
		o_rd_addr = 5'h00;
	end

	// Whole word per write; strobe stays up so writes can run back to back
	task automatic wr_word(input logic [1:0] a, input logic [15:0] d);
	begin
		o_out_wr = 1'b1;
		o_out_addr = a;
		o_out_data = d;
		@(posedge i_core_clk);
		#1;
	end
	endtask

	// Released lines show inverted data, not the last value
	task automatic idle();
	begin
		o_out_wr = 1'b0;
		o_out_addr = ~o_out_addr;
		o_out_data = ~o_out_data;
	end
	endtask

	// One byte read; answer is taken the cycle after the request edge
	task automatic rd_byte(input logic [4:0] a, output logic [7:0] d);
	begin
		o_rd_en = 1'b1;
		o_rd_addr = a;
		@(posedge i_core_clk);
		#1;
		o_rd_en = 1'b0;
		o_rd_addr = ~a;
		d = i_rd_valid === 1'b1 ? i_rd_data : 8'hXX;
		@(posedge i_core_clk);
		#1;
	end
	endtask
endmodule
`default_nettype wire

// ===== test/aod_diag_top_tb.sv
// Self-checking bench of the analog output diagnostics block
`default_nettype none
module aod_diag_top_tb
	import aod_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Signals
	logic clk;
	logic rstn;
	aod_status_t st;
	logic ovf;
	logic cerr;
	logic wr;
	logic [1:0] wa;
	logic [15:0] wd;
	logic re;
	logic [4:0] ra;
	logic [7:0] rdd;
	logic rv;
	logic [15:0] v0;
	logic [15:0] v1;
	logic [7:0] inb;
	logic [7:0] outb;
	aod_leds_t leds;
	int n_mismatch = 0;
	int comparisons = 0;
	int unsigned cyc = 0;

	// Short blink half period keeps the run brief
	aod_diag_top #(.BLINK_US(3)) u_dut (
		.i_core_clk(clk), .i_rstn(rstn), .i_status(st),
		.i_diag_buf_ovf(ovf), .i_comm_err(cerr),
		.i_out_wr(wr), .i_out_addr(wa), .i_out_data(wd),
		.i_rd_en(re), .i_rd_addr(ra), .o_rd_data(rdd), .o_rd_valid(rv),
		.o_output_value_ch0(v0), .o_output_value_ch1(v1),
		.o_in_area_bytes(inb), .o_out_area_bytes(outb), .o_leds(leds)
	);

	aod_host_model u_host (
		.i_core_clk(clk), .i_rd_data(rdd), .i_rd_valid(rv),
		.o_out_wr(wr), .o_out_addr(wa), .o_out_data(wd),
		.o_rd_en(re), .o_rd_addr(ra)
	);

	// ==========================================================
	// Clock and edge counter since reset release
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
		if (rstn)
			cyc <= cyc + 1;

	// ==========================================================
	// Compare and closing tasks
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
	begin
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %0t byte %h exp %h", $time, g, e);
		end
	end
	endtask

	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
	begin
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %0t word %h exp %h", $time, g, e);
		end
	end
	endtask

	// Counts and stamps depend on ticker phase, hence the tolerance
	task automatic cmp_near(input logic [31:0] g, input logic [31:0] e, input int unsigned t);
	begin
		comparisons++;
		if ($isunknown(g) || (g > e ? g - e : e - g) > t)
		begin
			n_mismatch++;
			$display("ERROR %0t value %0d exp %0d", $time, g, e);
		end
	end
	endtask

	task automatic complete_run();
	begin
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_const();
		logic [4:0] ia [7] = '{IDX_CH_TYPE, IDX_DIAG_BITS, IDX_CH_COUNT, 5'h0A, 5'h0F,
			IDX_MOD_INFO, IDX_RSVD_C};
		logic [7:0] ea [7] = '{8'h73, 8'h08, 8'h02, 8'h00, 8'h00, 8'h15, 8'h00};
		logic [7:0] d;
	begin
		for (int i = 0; i < 7; i++)
		begin
			u_host.rd_byte(ia[i], d);
			cmp8(d, ea[i]);
		end
		cmp8(inb, 8'h00);
		cmp8(outb, 8'h04);
		$display("test constants done");
	end
	endtask

	// Back-to-back writes, odd offsets must be ignored
	task automatic t_out();
	begin
		u_host.wr_word(2'h0, 16'hA5C3);
		u_host.wr_word(2'h2, 16'h3C5A);
		u_host.wr_word(2'h1, 16'hFFFF);
		u_host.wr_word(2'h3, 16'h0000);
		u_host.idle();
		cmp16(v0, 16'hA5C3);
		cmp16(v1, 16'h3C5A);
		$display("test output words done");
	end
	endtask

	task automatic t_event();
		logic [7:0] d;
	begin
		cerr = 1'b1;
		@(posedge clk);
		#1;
		cerr = 1'b0;
		u_host.rd_byte(IDX_INT_DIAG, d);
		cmp8(d, 8'h10);
		ovf = 1'b1;
		@(posedge clk);
		#1;
		ovf = 1'b0;
		u_host.rd_byte(IDX_INT_DIAG, d);
		cmp8(d, 8'h08);
		u_host.rd_byte(IDX_INT_DIAG, d);
		cmp8(d, 8'h00);
		$display("test internal events done");
	end
	endtask

	task automatic t_chan();
		logic [7:0] d;
	begin
		st.ch_param_err = 2'h1;
		st.ch_wire_break = 2'h2;
		repeat (5) @(posedge clk);
		#1;
		u_host.rd_byte(IDX_GRP_ERR, d);
		cmp8(d, 8'h03);
		u_host.rd_byte(IDX_CH0_ERR, d);
		cmp8(d, 8'h01);
		u_host.rd_byte(IDX_CH1_ERR, d);
		cmp8(d, 8'h10);
		// Summary byte: only the channel error bit, internal flags were read clear
		u_host.rd_byte(IDX_ERR_SUM, d);
		cmp8(d, 8'h08);
		$display("test channel bytes done");
	end
	endtask

	task automatic t_led();
		logic bt [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		logic mt [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		logic kt [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
		logic [7:0] et [4] = '{8'h0B, 8'h0C, 8'h04, 8'h00};
	begin
		st.ch_wire_break = 2'h0;
		st.ch_overload = 2'h2;
		for (int i = 0; i < 4; i++)
		begin
			st.bus_pwr_err = bt[i];
			st.module_err = mt[i];
			st.comm_ok = kt[i];
			repeat (5) @(posedge clk);
			#1;
			cmp8({4'h0, leds}, et[i]);
		end
		$display("test indicators done");
	end
	endtask

	// Fault toggles every 750 cycles with the shortened half period
	task automatic t_blink();
		logic last;
		int unsigned n;
	begin
		st = '0;
		st.comm_ok = 1'b1;
		st.cfg_err = 1'b1;
		n = 0;
		repeat (4) @(posedge clk);
		#1;
		last = leds.module_fault_indicator;
		repeat (3000)
		begin
			@(posedge clk);
			#1;
			if (leds.module_fault_indicator !== last)
				n++;
			last = leds.module_fault_indicator;
		end
		cmp_near(n, 32'd4, 0);
		st.cfg_err = 1'b0;
		$display("test blink done");
	end
	endtask

	task automatic rd_stamp(output logic [31:0] s);
		logic [7:0] b;
	begin
		for (int k = 0; k < 4; k++)
		begin
			u_host.rd_byte(IDX_STAMP0 + 5'(k), b);
			s[8*k +: 8] = b;
		end
	end
	endtask

	// Two events exactly 1000 cycles apart must differ by 4 ticks
	task automatic t_stamp();
		logic [31:0] s1;
		logic [31:0] s2;
		int unsigned c1;
	begin
		repeat (5) @(posedge clk);
		#1;
		cerr = 1'b1;
		@(posedge clk);
		#1;
		cerr = 1'b0;
		c1 = cyc;
		rd_stamp(s1);
		cmp_near(s1, c1 / 250, 1);
		while (cyc < c1 + 999)
		begin
			@(posedge clk);
			#1;
		end
		cerr = 1'b1;
		@(posedge clk);
		#1;
		cerr = 1'b0;
		rd_stamp(s2);
		cmp_near(s2 - s1, 32'd4, 0);
		$display("test timestamp done");
	end
	endtask

	// Mid-run reset clears all state; the first read follows the release at once
	task automatic t_reset();
		logic [7:0] d;
	begin
		rstn = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp16(v0, 16'h0000);
		cmp16(v1, 16'h0000);
		cmp8({3'h0, rv, leds}, 8'h00);
		cmp8(rdd, 8'h00);
		rstn = 1'b1;
		u_host.rd_byte(IDX_STAMP0, d);
		cmp8(d, 8'h00);
		u_host.rd_byte(IDX_CH_COUNT, d);
		cmp8(d, 8'h02);
		$display("test mid-run reset done");
	end
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		rstn = 1'b0;
		st = '0;
		ovf = 1'b0;
		cerr = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_const();
		t_out();
		t_event();
		t_chan();
		t_led();
		t_blink();
		t_stamp();
		t_reset();
		complete_run();
	end

	// Run needs about 16 us; six times that means a hang
	initial
	begin
		#100us;
		n_mismatch++;
		$display("ERROR %0t watchdog expired", $time);
		complete_run();
	end
endmodule
`default_nettype wire
